// *** rtl/pms_clk_div.sv ***
// Programmable divider giving a one-cycle enable pulse
`default_nettype none
module pms_clk_div #(
  parameter int DW = pms_pkg::DIV_W
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic [DW-1:0] divisor,
  output var  logic          tick
);
  logic [DW-1:0] cnt;

  // Pulse once every divisor+1 cycles
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else if (cnt >= divisor)
    begin
      cnt  <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + DW'(1);
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** rtl/pms_pkg.sv ***
// Shared constants and types for the power mode sequencer
`default_nettype none
package pms_pkg;
  // Operating states of the sequencer
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_WFI,
    MODE_HALT,
    MODE_STOP,
    MODE_START
  } pms_mode_e;

  // Clock source selection codes
  localparam logic [1:0] SRC_PLL = 2'h0;
  localparam logic [1:0] SRC_OSC = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [1:0] SRC_RST = SRC_PLL;

  // Divider and startup defaults
  localparam int DIV_W          = 8;
  localparam int STARTUP_CYCLES = 2048;

  // Pin synchroniser layout and reset values (supply assumed low at reset)
  localparam int          PIN_N       = 2;
  localparam int          PIN_WAKE    = 0;
  localparam int          PIN_SUPPLY  = 1;
  localparam logic [1:0]  PIN_RST_VAL = 2'h2;
endpackage
`default_nettype wire

// *** rtl/pms_power_mode_sequencer.sv ***
// Power mode sequencer: run, slow, wait, halt and stop control
// Function
// [R01] Wait instruction suspends code until interrupt acknowledged
// [R02] Waiting: CPU clock off, interrupt logic slow-clocked
// [R03] Halt with watchdog disabled stops everything
// [R04] Halt ignored while watchdog enabled
// [R05] Halt left only through reset
// [R06] Stop halts all until wake-up line
// [R07] Stop exit resumes saved context, no reset
// [R08] Watchdog counter frozen during stop
// [R09] Startup count holds operation after wake
// [R10] Slow mode clocks via programmable divider
// [R11] Run full speed, selectable clock source
// [R12] Static reset while supply below reference
// [R13] Startup count length is a parameter
`default_nettype none
module pms_power_mode_sequencer #(
  parameter int STARTUP_CYCLES = pms_pkg::STARTUP_CYCLES,
  parameter int DW             = pms_pkg::DIV_W
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                instr_wfi,
  input  wire logic                instr_halt,
  input  wire logic                instr_stop,
  input  wire logic                irq_ack,
  input  wire logic                wdg_enabled,
  input  wire logic                slow_req,
  input  wire logic [DW-1:0]       slow_div,
  input  wire logic [DW-1:0]       wfi_div,
  input  wire logic [1:0]          clk_src_sel,
  input  wire logic                wakeup_pin,
  input  wire logic                supply_low_pin,
  output var  pms_pkg::pms_mode_e  mode,
  output var  logic                exec_hold,
  output var  logic                cpu_clk_en,
  output var  logic                periph_clk_en,
  output var  logic                irq_clk_en,
  output var  logic [1:0]          clk_src,
  output var  logic                wdg_freeze,
  output var  logic                ctx_save,
  output var  logic                ctx_restore,
  output var  logic                static_reset
);
  localparam int         CW       = $clog2(STARTUP_CYCLES + 1);
  localparam logic [CW-1:0] START_LAST = CW'(STARTUP_CYCLES - 1);

  logic [pms_pkg::PIN_N-1:0] pin_raw;
  logic [pms_pkg::PIN_N-1:0] sync1;
  logic [pms_pkg::PIN_N-1:0] sync2;
  logic [pms_pkg::PIN_N-1:0] sync3;
  logic [pms_pkg::PIN_N-1:0] pin_filt;
  logic                      wake;
  logic                      supply_low;
  logic [CW-1:0]             start_cnt;
  logic [CW-1:0]             dwell;
  logic [DW-1:0]             div_sel;
  logic                      div_tick;
  pms_pkg::pms_mode_e        next_mode;
  logic                      next_cpu;
  logic                      next_per;

  assign pin_raw    = {supply_low_pin, wakeup_pin};
  assign wake       = pin_filt[pms_pkg::PIN_WAKE];
  assign supply_low = pin_filt[pms_pkg::PIN_SUPPLY];

  // Three-stage synchronisers; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < pms_pkg::PIN_N; gi++)
    begin : g_sync
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1[gi]    <= pms_pkg::PIN_RST_VAL[gi];
          sync2[gi]    <= pms_pkg::PIN_RST_VAL[gi];
          sync3[gi]    <= pms_pkg::PIN_RST_VAL[gi];
          pin_filt[gi] <= pms_pkg::PIN_RST_VAL[gi];
        end
        else
        begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi])
          begin
            pin_filt[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  // Static reset follows the filtered supply detector
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      static_reset <= 1'b1;
    else
      static_reset <= supply_low; // R12
  end

  // Reduced-rate tick: waiting rate in wait mode, slow rate otherwise
  assign div_sel = (mode == pms_pkg::MODE_WFI) ? wfi_div : slow_div;

  pms_clk_div #(
    .DW (DW)
  ) u_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .divisor  (div_sel),
    .tick     (div_tick)
  );

  // Mode transitions; stop beats halt, and halt with watchdog disabled beats wait, when issued together
  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      pms_pkg::MODE_RUN:
      begin
        if (instr_stop)
          next_mode = pms_pkg::MODE_STOP; // R06
        else if (instr_halt && !wdg_enabled)
          next_mode = pms_pkg::MODE_HALT; // R03 R04
        else if (instr_wfi)
          next_mode = pms_pkg::MODE_WFI; // R01
      end
      pms_pkg::MODE_WFI:
        if (irq_ack)
          next_mode = pms_pkg::MODE_RUN; // R01
      pms_pkg::MODE_HALT:
        next_mode = pms_pkg::MODE_HALT; // R05
      pms_pkg::MODE_STOP:
        if (wake)
          next_mode = pms_pkg::MODE_START; // R06
      pms_pkg::MODE_START:
        if (start_cnt == '0)
          next_mode = pms_pkg::MODE_RUN; // R09
      default:
        next_mode = pms_pkg::MODE_RUN;
    endcase
    if (static_reset)
      next_mode = pms_pkg::MODE_RUN; // R05 R12
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode <= pms_pkg::MODE_RUN;
    else
      mode <= next_mode;
  end

  // Oscillator startup counter
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      start_cnt <= '0;
    else if (mode == pms_pkg::MODE_STOP)
      start_cnt <= START_LAST; // R09 R13
    else if (mode == pms_pkg::MODE_START && start_cnt != '0)
      start_cnt <= start_cnt - CW'(1);
  end

  // Clock gating per mode
  always_comb
  begin
    next_cpu = 1'b0;
    next_per = 1'b0;
    if (!static_reset)
    begin
      unique case (next_mode)
        pms_pkg::MODE_RUN:
        begin
          next_cpu = slow_req ? div_tick : 1'b1; // R10 R11
          next_per = next_cpu;
        end
        pms_pkg::MODE_WFI:
          next_per = div_tick; // R02
        default:
        begin
          next_cpu = 1'b0; // R03 R06
          next_per = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_clk_en    <= 1'b0;
      periph_clk_en <= 1'b0;
      irq_clk_en    <= 1'b0;
      exec_hold     <= 1'b1;
    end
    else
    begin
      cpu_clk_en    <= next_cpu;
      periph_clk_en <= next_per;
      irq_clk_en    <= next_per; // R02
      exec_hold     <= static_reset || next_mode != pms_pkg::MODE_RUN; // R01 R09
    end
  end

  // Clock source; the unused code keeps the previous choice
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      clk_src <= pms_pkg::SRC_RST;
    else if (clk_src_sel == pms_pkg::SRC_PLL || clk_src_sel == pms_pkg::SRC_OSC
             || clk_src_sel == pms_pkg::SRC_EXT)
      clk_src <= clk_src_sel; // R11
  end

  // Watchdog freeze and context save/restore strobes
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdg_freeze  <= 1'b0;
      ctx_save    <= 1'b0;
      ctx_restore <= 1'b0;
    end
    else
    begin
      wdg_freeze  <= wdg_enabled && (next_mode == pms_pkg::MODE_STOP
                     || next_mode == pms_pkg::MODE_START); // R08
      ctx_save    <= mode == pms_pkg::MODE_RUN && next_mode == pms_pkg::MODE_STOP; // R07
      ctx_restore <= mode == pms_pkg::MODE_START && next_mode == pms_pkg::MODE_RUN
                     && !static_reset; // R07
    end
  end

  // Cycles spent in startup, for checking only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      dwell <= '0;
    else if (mode == pms_pkg::MODE_START)
      dwell <= dwell + CW'(1);
    else
      dwell <= '0;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_wfi_exit: assert property (mode == pms_pkg::MODE_WFI && irq_ack && !static_reset // R01
    |=> mode == pms_pkg::MODE_RUN && !exec_hold) else $error("wait not left on ack");
  a_wfi_cpu_off: assert property (mode == pms_pkg::MODE_WFI && !irq_ack // R02
    |=> !cpu_clk_en && irq_clk_en == periph_clk_en) else $error("cpu clock in wait");
  a_halt_entry: assert property (mode == pms_pkg::MODE_RUN && instr_halt && !instr_stop // R03
    && !wdg_enabled && !static_reset |=> mode == pms_pkg::MODE_HALT ##1 !periph_clk_en)
    else $error("halt not entered");
  a_halt_ignored: assert property (mode == pms_pkg::MODE_RUN && instr_halt && wdg_enabled // R04
    |=> mode != pms_pkg::MODE_HALT) else $error("halt taken with watchdog on");
  a_halt_sticky: assert property (mode == pms_pkg::MODE_HALT && !static_reset // R05
    |=> mode == pms_pkg::MODE_HALT) else $error("halt left without reset");
  a_stop_wait: assert property (mode == pms_pkg::MODE_STOP && !wake && !static_reset // R06
    |=> mode == pms_pkg::MODE_STOP ##0 !cpu_clk_en) else $error("stop left without wake");
  a_ctx_restore: assert property (ctx_restore // R07
    |-> $past(mode) == pms_pkg::MODE_START && !$past(static_reset)) else $error("bad restore");
  a_wdg_frozen: assert property (mode == pms_pkg::MODE_STOP && wdg_enabled && !static_reset // R08
    |=> wdg_freeze) else $error("watchdog not frozen in stop");
  a_start_hold: assert property (mode == pms_pkg::MODE_START && dwell < START_LAST // R09
    && !static_reset |=> mode == pms_pkg::MODE_START) else $error("startup cut short");
  a_start_len: assert property (mode == pms_pkg::MODE_START && dwell == START_LAST // R13
    && !static_reset |=> mode == pms_pkg::MODE_RUN) else $error("startup overran");
  a_slow_gate: assert property (mode == pms_pkg::MODE_RUN && slow_req && !div_tick // R10
    && !instr_wfi && !instr_stop && !instr_halt |=> !cpu_clk_en) else $error("slow gate");
  a_full_speed: assert property (mode == pms_pkg::MODE_RUN && !slow_req && !static_reset // R11
    && !instr_wfi && !instr_stop && !instr_halt |=> cpu_clk_en && periph_clk_en)
    else $error("run not full speed");
  a_static_rst: assert property (supply_low |=> static_reset ##1 mode == pms_pkg::MODE_RUN // R12
    && exec_hold) else $error("static reset missing");
endmodule
`default_nettype wire

// *** sim/pms_power_mode_sequencer_tb.sv ***
// Self-checking bench for the power mode sequencer
`default_nettype none
module pms_power_mode_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 8;
  logic               core_clk, rst_n, instr_wfi, instr_halt, instr_stop, irq_ack;
  logic               wdg_enabled, slow_req, wakeup_pin, supply_low_pin;
  logic [7:0]         slow_div, wfi_div;
  logic [1:0]         clk_src_sel, clk_src;
  pms_pkg::pms_mode_e mode;
  logic               exec_hold, cpu_clk_en, periph_clk_en, irq_clk_en;
  logic               wdg_freeze, ctx_save, ctx_restore, static_reset;
  int                 n_mismatch;
  int                 checks_done;

  pms_power_mode_sequencer #(.STARTUP_CYCLES(SC), .DW(8)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .instr_wfi(instr_wfi), .instr_halt(instr_halt),
    .instr_stop(instr_stop), .irq_ack(irq_ack), .wdg_enabled(wdg_enabled),
    .slow_req(slow_req), .slow_div(slow_div), .wfi_div(wfi_div),
    .clk_src_sel(clk_src_sel), .wakeup_pin(wakeup_pin), .supply_low_pin(supply_low_pin),
    .mode(mode), .exec_hold(exec_hold), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .irq_clk_en(irq_clk_en), .clk_src(clk_src),
    .wdg_freeze(wdg_freeze), .ctx_save(ctx_save), .ctx_restore(ctx_restore),
    .static_reset(static_reset));

  always #10 core_clk = ~core_clk;

  task automatic summarize();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  task automatic wait_mode(input pms_pkg::pms_mode_e m);
    for (int i = 0; i < 40 && mode !== m; i++)
      step(1);
    check("mode reached", 8'(m), 8'(mode));
    if (mode !== m)
      summarize();
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    step(3);
    rst_n = 1'b1;
    check("static_reset", 8'h01, 8'(static_reset));
    step(6);
    check("static_reset", 8'h00, 8'(static_reset));
    check("mode", 8'(pms_pkg::MODE_RUN), 8'(mode));
    check("cpu_clk_en", 8'h01, 8'(cpu_clk_en));
  endtask

  task automatic t_wfi();
    int ni;
    int np;
    ni = 0;
    np = 0;
    wfi_div = 8'h01;
    pulse(instr_wfi);
    check("mode", 8'(pms_pkg::MODE_WFI), 8'(mode));
    step(1);
    check("cpu_clk_en", 8'h00, 8'(cpu_clk_en));
    check("exec_hold", 8'h01, 8'(exec_hold));
    for (int i = 0; i < 8; i++)
    begin
      ni += int'(irq_clk_en === 1'b1);
      np += int'(periph_clk_en === 1'b1);
      step(1);
    end
    check("irq_clk_en count", 8'h04, 8'(ni));
    check("periph_clk_en count", 8'h04, 8'(np));
    check("cpu_clk_en", 8'h00, 8'(cpu_clk_en));
    pulse(irq_ack);
    check("mode", 8'(pms_pkg::MODE_RUN), 8'(mode));
    step(1);
    check("exec_hold", 8'h00, 8'(exec_hold));
    check("cpu_clk_en", 8'h01, 8'(cpu_clk_en));
  endtask

  task automatic t_halt();
    wdg_enabled = 1'b1;
    pulse(instr_halt);
    step(2);
    check("mode", 8'(pms_pkg::MODE_RUN), 8'(mode));
    check("cpu_clk_en", 8'h01, 8'(cpu_clk_en));
    wdg_enabled = 1'b0;
    pulse(instr_halt);
    check("mode", 8'(pms_pkg::MODE_HALT), 8'(mode));
    step(1);
    check("cpu_clk_en", 8'h00, 8'(cpu_clk_en));
    check("periph_clk_en", 8'h00, 8'(periph_clk_en));
    pulse(irq_ack);
    wakeup_pin = 1'b1;
    step(8);
    wakeup_pin = 1'b0;
    check("mode", 8'(pms_pkg::MODE_HALT), 8'(mode));
    do_reset();
  endtask

  task automatic t_stop();
    int n;
    n = 0;
    wdg_enabled = 1'b1;
    pulse(instr_stop);
    check("mode", 8'(pms_pkg::MODE_STOP), 8'(mode));
    check("ctx_save", 8'h01, 8'(ctx_save));
    check("wdg_freeze", 8'h01, 8'(wdg_freeze));
    step(10);
    check("mode", 8'(pms_pkg::MODE_STOP), 8'(mode));
    check("cpu_clk_en", 8'h00, 8'(cpu_clk_en));
    check("ctx_save", 8'h00, 8'(ctx_save));
    wakeup_pin = 1'b1;
    wait_mode(pms_pkg::MODE_START);
    check("exec_hold", 8'h01, 8'(exec_hold));
    check("wdg_freeze", 8'h01, 8'(wdg_freeze));
    while (mode === pms_pkg::MODE_START && n < 100)
    begin
      n++;
      step(1);
    end
    check("startup count", 8'(SC), 8'(n));
    if (n >= 100)
      summarize();
    check("ctx_restore", 8'h01, 8'(ctx_restore));
    check("wdg_freeze", 8'h00, 8'(wdg_freeze));
    check("static_reset", 8'h00, 8'(static_reset));
    wakeup_pin = 1'b0;
    step(1);
    check("exec_hold", 8'h00, 8'(exec_hold));
    check("ctx_restore", 8'h00, 8'(ctx_restore));
  endtask

  task automatic t_slow();
    int n;
    n = 0;
    slow_req = 1'b1;
    slow_div = 8'h03;
    step(4);
    for (int i = 0; i < 16; i++)
    begin
      n += int'(cpu_clk_en === 1'b1);
      step(1);
    end
    check("slow cpu_clk_en count", 8'h04, 8'(n));
    slow_req = 1'b0;
    step(4);
    check("cpu_clk_en", 8'h01, 8'(cpu_clk_en));
  endtask

  task automatic t_src();
    logic [1:0] sel [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
    logic [1:0] exp [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
    for (int i = 0; i < 4; i++)
    begin
      clk_src_sel = sel[i];
      step(2);
      check("clk_src", 8'(exp[i]), 8'(clk_src));
    end
  endtask

  task automatic t_supply();
    supply_low_pin = 1'b1;
    for (int i = 0; i < 10 && static_reset !== 1'b1; i++)
      step(1);
    check("static_reset", 8'h01, 8'(static_reset));
    if (static_reset !== 1'b1)
      summarize();
    step(22);
    check("static_reset", 8'h01, 8'(static_reset));
    check("cpu_clk_en", 8'h00, 8'(cpu_clk_en));
    check("exec_hold", 8'h01, 8'(exec_hold));
    supply_low_pin = 1'b0;
    step(8);
    check("static_reset", 8'h00, 8'(static_reset));
    check("cpu_clk_en", 8'h01, 8'(cpu_clk_en));
  endtask

  initial
  begin
    core_clk = 1'b0;
    {instr_wfi, instr_halt, instr_stop, irq_ack, wakeup_pin} = 5'h00;
    {wdg_enabled, slow_req, supply_low_pin} = 3'h0;
    slow_div = 8'h00;
    wfi_div = 8'h00;
    clk_src_sel = 2'h0;
    rst_n = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    do_reset();
    t_wfi();
    t_halt();
    t_stop();
    t_slow();
    t_src();
    t_supply();
    summarize();
  end
endmodule
`default_nettype wire
